// ===== hw/ppmt_timer.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module ppmt_timer
   import ppmt_pkg::*;
#(
   parameter int AW = 12
)(
   // Clock and reset.
   input  wire logic          clock,
   input  wire logic          rstn,
   // Write address and data channels.
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   // Write response channel.
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // Read channels.
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Measured pulse and interrupt request.
   input  wire logic          measured_input_pin,
   output logic               timer_irq
);
   typedef struct packed {
      logic       wr_rdy;
      logic       bvalid;
      logic [1:0] bresp;
      logic       ar_rdy;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic       start;
      logic       stat;
      logic       eflag;
      logic       uflag;
      logic [7:0] ioc;
      logic [7:0] mode;
      logic [7:0] pre_rld;
      logic [7:0] pre_cnt;
      logic [7:0] tmr_rld;
      logic [7:0] tmr_cnt;
      logic [7:0] rbuf;
      logic       buf_full;
      logic       edge_pend;
      logic       cap_done;
      logic       lvl_d;
      logic [4:0] div;
      logic       irq;
   } ppmt_state_s;

   ppmt_state_s r_reg;
   ppmt_state_s r_next;

   logic       level;
   logic       cs_en;
   logic       smp_en;
   logic       edge_ev;
   logic       pre_uf;
   logic       uf_ev;
   logic       reload_ev;
   logic       wr_go;
   logic       rd_go;
   logic [9:0] wr_idx;
   logic [9:0] rd_idx;
   logic [7:0] wd;
   logic       period_mode;

   // Picks one enable of the shared divider for a rate code.
   function automatic logic rate_tick(input logic [1:0] k, input logic [4:0] d);
      logic t;
      t = 1'b1;
      unique case (k)
         RATE_F1:  t = 1'b1;
         RATE_F2:  t = d[0];
         RATE_F8:  t = &d[2:0];
         RATE_F32: t = &d;
      endcase
      return t;
   endfunction

   // Input filter; its sample rate comes from the same divider.
   ppmt_filter u_filter (
      .clock     (clock),
      .rstn      (rstn),
      .pin       (measured_input_pin),
      .enable    (|r_reg.ioc[IOC_FLT_HI:IOC_FLT_LO]),
      .sample_en (smp_en),
      .level     (level)
   );

   // Whole next state: counting first, then bus writes, then flag sets.
   always_comb begin
      r_next      = r_reg;
      wr_idx      = s_axi_awaddr[11:2];
      rd_idx      = s_axi_araddr[11:2];
      wd          = s_axi_wdata[7:0];
      wr_go       = r_reg.wr_rdy;
      rd_go       = r_reg.ar_rdy;
      period_mode = (r_reg.mode[MODE_OP_HI:MODE_OP_LO] == MODE_PERIOD);
      pre_uf      = 1'b0;
      uf_ev       = 1'b0;
      reload_ev   = 1'b0;
      r_next.div  = r_reg.div + 5'h01;
      r_next.irq  = 1'b0;
      cs_en  = rate_tick(r_reg.mode[MODE_SRC_HI:MODE_SRC_LO], r_reg.div);
      smp_en = rate_tick({r_reg.ioc[IOC_FLT_HI],
                          &r_reg.ioc[IOC_FLT_HI:IOC_FLT_LO]}, r_reg.div);
      // Selected edge as a one-cycle pulse, only while counting.
      r_next.lvl_d = level;
      edge_ev = r_reg.stat && (r_reg.ioc[IOC_POL] ? (!level && r_reg.lvl_d)
                                                  : (level && !r_reg.lvl_d));
      // Status lags start by up to one count-source cycle.
      if (cs_en) begin
         r_next.stat = r_reg.start;
      end
      // Prescaler and timer count only while the status says so.
      if (r_reg.stat && cs_en) begin
         if (r_reg.pre_cnt == 8'h00) begin
            r_next.pre_cnt = r_reg.pre_rld;
            pre_uf = 1'b1;
         end else begin
            r_next.pre_cnt = r_reg.pre_cnt - 8'h01;
         end
      end
      if (pre_uf) begin
         if (r_reg.cap_done) begin
            r_next.tmr_cnt  = r_reg.tmr_rld;
            r_next.cap_done = 1'b0;
            reload_ev = 1'b1;
            uf_ev = (r_reg.tmr_cnt == 8'h00);
         end else begin
            if (r_reg.tmr_cnt == 8'h00) begin
               r_next.tmr_cnt = r_reg.tmr_rld;
               uf_ev = 1'b1;
            end else begin
               r_next.tmr_cnt = r_reg.tmr_cnt - 8'h01;
            end
            if (r_reg.edge_pend) begin
               r_next.edge_pend = 1'b0;
               r_next.cap_done  = 1'b1;
               // An unread result is kept; the new one is lost.
               if (!r_reg.buf_full) begin
                  r_next.rbuf     = r_reg.tmr_cnt;
                  r_next.buf_full = 1'b1;
               end
            end
         end
      end
      // Edge state left from before a start must not raise the flag early.
      if (!r_reg.stat) begin
         r_next.edge_pend = 1'b0;
         r_next.cap_done  = 1'b0;
      end
      if (edge_ev) begin
         r_next.edge_pend = 1'b1;
      end
      r_next.irq = uf_ev || reload_ev || edge_ev;
      // Write channel: ready is offered once both address and data wait.
      if (!r_reg.wr_rdy && !r_reg.bvalid && s_axi_awvalid && s_axi_wvalid) begin
         r_next.wr_rdy = 1'b1;
      end
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (wr_go) begin
         r_next.wr_rdy = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp  = RESP_OKAY;
         unique case (wr_idx)
            IDX_CTRL: begin
               if (s_axi_wstrb[0]) begin
                  r_next.start = wd[CTRL_START];
                  // Zero clears a flag, one leaves it alone.
                  if (!wd[CTRL_EDGE]) r_next.eflag = 1'b0;
                  if (!wd[CTRL_UNDF]) r_next.uflag = 1'b0;
                  if (wd[CTRL_FSTOP]) begin
                     r_next.start     = 1'b0;
                     r_next.stat      = 1'b0;
                     r_next.pre_rld   = RST_TMR;
                     r_next.pre_cnt   = RST_TMR;
                     r_next.tmr_rld   = RST_TMR;
                     r_next.tmr_cnt   = RST_TMR;
                     r_next.edge_pend = 1'b0;
                     r_next.cap_done  = 1'b0;
                  end
               end
            end
            IDX_IOC: begin
               if (s_axi_wstrb[0]) r_next.ioc = wd;
            end
            IDX_MODE: begin
               if (s_axi_wstrb[0]) r_next.mode = wd;
            end
            IDX_PRE: begin
               if (s_axi_wstrb[0]) begin
                  r_next.pre_rld = wd;
                  r_next.pre_cnt = wd;
               end
            end
            IDX_CNT: begin
               if (s_axi_wstrb[0]) begin
                  r_next.tmr_rld = wd;
                  r_next.tmr_cnt = wd;
               end
            end
            default: r_next.bresp = RESP_SLVERR;
         endcase
      end
      // Hardware sets win over a clear in the same cycle.
      if (reload_ev) r_next.eflag = 1'b1;
      if (uf_ev) r_next.uflag = 1'b1;
      // Read channel.
      if (!r_reg.ar_rdy && !r_reg.rvalid && s_axi_arvalid) begin
         r_next.ar_rdy = 1'b1;
      end
      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (rd_go) begin
         r_next.ar_rdy = 1'b0;
         r_next.rvalid = 1'b1;
         r_next.rresp  = RESP_OKAY;
         r_next.rdata  = RST_BYTE;
         // Each register is its own byte, so a pair read is two accesses.
         unique case (rd_idx)
            IDX_CTRL: begin
               r_next.rdata[CTRL_START] = r_reg.start;
               r_next.rdata[CTRL_STAT]  = r_reg.stat;
               r_next.rdata[CTRL_UNDF]  = r_reg.uflag;
               r_next.rdata[CTRL_EDGE]  = r_reg.eflag;
            end
            IDX_IOC:  r_next.rdata = r_reg.ioc;
            IDX_MODE: r_next.rdata = r_reg.mode;
            IDX_PRE:  r_next.rdata = r_reg.pre_cnt;
            IDX_CNT: begin
               if (period_mode) begin
                  r_next.rdata    = r_reg.rbuf;
                  // A capture in this same cycle stays held: the set wins over the read.
                  r_next.buf_full = r_next.buf_full && !r_reg.buf_full;
               end else begin
                  r_next.rdata = r_reg.tmr_cnt;
               end
            end
            default: r_next.rresp = RESP_SLVERR;
         endcase
      end
   end

   // Reset leaves the timer stopped with both flags clear.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r_reg         <= '0;
         r_reg.pre_rld <= RST_TMR;
         r_reg.pre_cnt <= RST_TMR;
         r_reg.tmr_rld <= RST_TMR;
         r_reg.tmr_cnt <= RST_TMR;
      end else begin
         r_reg <= r_next;
      end
   end

   // Every output is a state bit, except the upper 24 bits of rdata, which are zero.
   assign s_axi_awready = r_reg.wr_rdy;
   assign s_axi_wready  = r_reg.wr_rdy;
   assign s_axi_bvalid  = r_reg.bvalid;
   assign s_axi_bresp   = r_reg.bresp;
   assign s_axi_arready = r_reg.ar_rdy;
   assign s_axi_rvalid  = r_reg.rvalid;
   assign s_axi_rresp   = r_reg.rresp;
   assign s_axi_rdata   = {24'h000000, r_reg.rdata};
   assign timer_irq     = r_reg.irq;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   start_follow_a: assert property (r_reg.start && !r_reg.stat && !wr_go |->
      ##[1:32] (r_reg.stat || !r_reg.start)) else $error("status did not follow start");
   stop_follow_a: assert property (!r_reg.start && r_reg.stat |->
      ##[1:32] (!r_reg.stat || r_reg.start)) else $error("status did not follow stop");
   stopped_hold_a: assert property (!r_reg.stat && !wr_go |=>
      $stable(r_reg.tmr_cnt) && $stable(r_reg.pre_cnt)) else $error("count moved while stopped");
   reload_flag_a: assert property (r_reg.cap_done && pre_uf |=>
      r_reg.eflag && r_reg.tmr_cnt == $past(r_reg.tmr_rld)) else $error("reload missed edge flag");
   both_flags_a: assert property (reload_ev && r_reg.tmr_cnt == 8'h00 |=>
      r_reg.eflag && r_reg.uflag) else $error("coincident events lost a flag");
   flag_keep_a: assert property (wr_go && wr_idx == IDX_CTRL && s_axi_wstrb[0] &&
      wd[CTRL_EDGE] && r_reg.eflag |=> r_reg.eflag) else $error("writing one cleared flag");
   flag_clear_a: assert property (wr_go && wr_idx == IDX_CTRL && s_axi_wstrb[0] &&
      !wd[CTRL_UNDF] && !uf_ev |=> !r_reg.uflag) else $error("writing zero kept flag");
   buf_hold_a: assert property (r_reg.buf_full && !rd_go |=>
      $stable(r_reg.rbuf)) else $error("held buffer overwritten");
   read_buf_a: assert property (rd_go && rd_idx == IDX_CNT && period_mode |=>
      s_axi_rvalid && s_axi_rdata[7:0] == $past(r_reg.rbuf)) else $error("counter read not buffer");
   capture_step_a: assert property (r_reg.edge_pend && pre_uf && !r_reg.cap_done |=>
      r_reg.cap_done && !r_reg.edge_pend) else $error("capture step skipped");
   irq_cause_a: assert property (edge_ev || uf_ev || reload_ev |=>
      timer_irq) else $error("interrupt request missing");
   force_stop_a: assert property (wr_go && wr_idx == IDX_CTRL && s_axi_wstrb[0] &&
      wd[CTRL_FSTOP] |=> !r_reg.start && !r_reg.stat) else $error("forced stop ignored");
   edge_pol_a: assert property (edge_ev |-> r_reg.stat && $changed(level) &&
      (level ^ r_reg.ioc[IOC_POL])) else $error("edge of wrong polarity taken");
   buf_setwin_a: assert property (r_reg.edge_pend && pre_uf && !r_reg.cap_done &&
      !r_reg.buf_full |=> r_reg.buf_full) else $error("capture not held");

   period_cov_c: cover property (reload_ev ##1 rd_go && rd_idx == IDX_CNT);
   coincide_cov_c: cover property (reload_ev && uf_ev);
   start_cov_c: cover property (r_reg.start && !r_reg.stat ##1 r_reg.stat);
   fall_cov_c: cover property (edge_ev && r_reg.ioc[IOC_POL]);
endmodule

// ===== hw/ppmt_pkg.sv
package ppmt_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [9:0] IDX_CTRL = 10'h100;
   localparam logic [9:0] IDX_IOC  = 10'h101;
   localparam logic [9:0] IDX_MODE = 10'h102;
   localparam logic [9:0] IDX_PRE  = 10'h103;
   localparam logic [9:0] IDX_CNT  = 10'h104;
   // Control register fields.
   localparam int CTRL_START = 0;
   localparam int CTRL_STAT  = 1;
   localparam int CTRL_FSTOP = 2;
   localparam int CTRL_UNDF  = 4;
   localparam int CTRL_EDGE  = 5;
   // Pin io control fields.
   localparam int IOC_POL    = 0;
   localparam int IOC_FLT_LO = 4;
   localparam int IOC_FLT_HI = 5;
   // Mode register fields.
   localparam int MODE_OP_LO = 0;
   localparam int MODE_OP_HI = 2;
   localparam int MODE_SRC_LO = 4;
   localparam int MODE_SRC_HI = 5;
   localparam logic [2:0] MODE_PERIOD = 3'h3;
   // Rate codes shared by count source and filter sampling.
   localparam logic [1:0] RATE_F1  = 2'h0;
   localparam logic [1:0] RATE_F2  = 2'h1;
   localparam logic [1:0] RATE_F8  = 2'h2;
   localparam logic [1:0] RATE_F32 = 2'h3;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_TMR  = 8'hff;
   // Filter agreement count.
   localparam int FLT_SAMPLES = 3;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/ppmt_filter.sv
`timescale 1ns/1ps
module ppmt_filter
   import ppmt_pkg::*;
(
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rstn,
   // Pin and filter control.
   input  wire logic       pin,
   input  wire logic       enable,
   input  wire logic       sample_en,
   // Accepted level.
   output logic            level
);
   typedef struct packed {
      logic [FLT_SAMPLES-1:0] hist;
      logic                   lvl;
   } ppmt_filt_s;

   ppmt_filt_s r_reg;
   ppmt_filt_s r_next;

   // With the filter enabled, the level moves only once every recent sample agrees; disabled, it follows the pin.
   always_comb begin
      r_next = r_reg;
      if (!enable) begin
         r_next.lvl = pin;
      end else if (sample_en) begin
         r_next.hist = {r_reg.hist[FLT_SAMPLES-2:0], pin};
         if (&r_reg.hist || ~|r_reg.hist) begin
            r_next.lvl = r_reg.hist[0];
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign level = r_reg.lvl;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   filter_agree_a: assert property (enable && $past(enable) && $changed(level) |->
      $past(&r_reg.hist || ~|r_reg.hist)) else $error("filter level moved without agreement");
endmodule

// ===== tb/ppmt_pulse_src.sv
`timescale 1ns/1ps
module ppmt_pulse_src (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rstn,
   // Pulse shape; while run is low the pin follows idle_level.
   input  wire logic        run,
   input  wire logic [15:0] hi_len,
   input  wire logic [15:0] lo_len,
   input  wire logic        idle_level,
   // Measured pulse towards the timer.
   output logic             pin
);
   logic [15:0] cnt_reg;

   // Square wave whose levels each last their full length; the bench picks lengths
   // above one prescaler period, since shorter ones may be dropped by the timer.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin     <= 1'b0;
         cnt_reg <= 16'h0000;
      end else if (!run) begin
         pin     <= idle_level;
         cnt_reg <= 16'h0000;
      end else if (cnt_reg + 16'h0001 >= (pin ? hi_len : lo_len)) begin
         pin     <= ~pin;
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
endmodule

// ===== tb/pulse_period_measure_timer_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module pulse_period_measure_timer_test
   import ppmt_pkg::*;
;
   logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, pin, irq, run, idle_level;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] hi_len, lo_len;
   int          n_mismatch, checks, irq_n;

   ppmt_timer #(.AW(12)) u_ppmt_timer (.clock(clock), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .measured_input_pin(pin), .timer_irq(irq));
   ppmt_pulse_src u_ppmt_pulse_src (.clock(clock), .rstn(rstn), .run(run), .hi_len(hi_len),
      .lo_len(lo_len), .idle_level(idle_level), .pin(pin));

   // Free clock at 100 MHz.
   always #5 clock = ~clock;

   // Interrupt pulses are counted so a scenario can see that some arrived.
   always @(posedge clock) begin
      if (irq === 1'b1) irq_n++;
   end

   function automatic logic [11:0] ba(input logic [9:0] i);
      return {i, 2'b00};
   endfunction

   // Address and data are offered together and each is dropped once taken.
   task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
      @(posedge clock);
      awaddr  <= {i, 2'b00};
      wdata   <= {24'h000000, d};
      wstrb   <= 4'h1;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clock);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("bresp", er, bresp)
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
      @(posedge clock);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clock);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata[7:0];
      r = rresp;
   endtask

   task automatic rd_chk(input logic [9:0] i, input logic [7:0] e, input string nm);
      logic [7:0] d;
      logic [1:0] r;
      rd(ba(i), d, r);
      `CHK(nm, e, d)
      `CHK({nm, "_rresp"}, RESP_OKAY, r)
   endtask

   // Polls the control register; the bound keeps a stuck flag from hanging the run.
   task automatic wait_ctrl(input int b, input logic v, input int n, input string nm);
      logic [7:0] d;
      logic [1:0] r;
      repeat (n) begin
         rd(ba(IDX_CTRL), d, r);
         if (d[b] === v) break;
      end
      `CHK(nm, v, d[b])
   endtask

   task automatic t_reset;
      logic [7:0] d;
      logic [1:0] r;
      rd_chk(IDX_CTRL, RST_BYTE, "ctrl_rst");
      rd_chk(IDX_IOC, RST_BYTE, "ioc_rst");
      rd_chk(IDX_MODE, RST_BYTE, "mode_rst");
      rd_chk(IDX_PRE, RST_TMR, "pre_rst");
      rd_chk(IDX_CNT, RST_TMR, "cnt_rst");
      rd(12'h414, d, r);
      `CHK("unmapped_rresp", RESP_SLVERR, r)
      wr(10'h105, 8'h5a, RESP_SLVERR);
      wr(IDX_IOC, 8'h31, RESP_OKAY);
      rd_chk(IDX_IOC, 8'h31, "ioc_rw");
   endtask

   task automatic t_start_stop;
      logic [7:0] d0, d1;
      logic [1:0] r;
      for (int s = 0; s < 4; s++) begin
         wr(IDX_MODE, {2'b00, s[1:0], 4'h3}, RESP_OKAY);
         wr(IDX_CTRL, 8'h31, RESP_OKAY);
         wait_ctrl(CTRL_STAT, 1'b1, (s == 0) ? 1 : 12, "stat_on");
         wr(IDX_CTRL, 8'h30, RESP_OKAY);
         wait_ctrl(CTRL_STAT, 1'b0, (s == 0) ? 1 : 12, "stat_off");
      end
      wr(IDX_MODE, 8'h00, RESP_OKAY);
      wr(IDX_PRE, 8'h40, RESP_OKAY);
      wr(IDX_CTRL, 8'h31, RESP_OKAY);
      wait_ctrl(CTRL_STAT, 1'b1, 1, "stat_f1");
      rd(ba(IDX_PRE), d0, r);
      rd(ba(IDX_PRE), d1, r);
      `CHK("pre_live", 1'b1, d0 != d1)
      wr(IDX_CTRL, 8'h34, RESP_OKAY);
      rd(ba(IDX_CTRL), d0, r);
      `CHK("fstop_ctrl", 3'h0, d0[2:0])
      rd_chk(IDX_PRE, RST_TMR, "fstop_pre");
      rd_chk(IDX_CNT, RST_TMR, "fstop_cnt");
   endtask

   task automatic t_flags;
      logic [7:0] d;
      logic [1:0] r;
      int         n0;
      n0 = irq_n;
      wr(IDX_IOC, 8'h00, RESP_OKAY);
      wr(IDX_MODE, 8'h03, RESP_OKAY);
      wr(IDX_PRE, 8'h03, RESP_OKAY);
      wr(IDX_CNT, 8'h02, RESP_OKAY);
      wr(IDX_CTRL, 8'h00, RESP_OKAY);
      wr(IDX_CTRL, 8'h31, RESP_OKAY);
      repeat (10) @(posedge clock);
      idle_level <= 1'b1;
      repeat (20) @(posedge clock);
      idle_level <= 1'b0;
      wait_ctrl(CTRL_EDGE, 1'b1, 10, "edge_set");
      wait_ctrl(CTRL_UNDF, 1'b1, 10, "undf_set");
      wr(IDX_CTRL, 8'h30, RESP_OKAY);
      wait_ctrl(CTRL_STAT, 1'b0, 3, "stat_off2");
      wr(IDX_CTRL, 8'h20, RESP_OKAY);
      rd(ba(IDX_CTRL), d, r);
      `CHK("clear_undf", 2'b10, d[5:4])
      wr(IDX_CTRL, 8'h10, RESP_OKAY);
      rd(ba(IDX_CTRL), d, r);
      `CHK("clear_edge", 2'b00, d[5:4])
      `CHK("irq_seen", 1'b1, irq_n > n0)
   endtask

   task automatic t_polarity;
      logic [7:0] d;
      logic [1:0] r;
      wr(IDX_CNT, 8'hff, RESP_OKAY);
      wr(IDX_IOC, 8'h01, RESP_OKAY);
      wr(IDX_CTRL, 8'h00, RESP_OKAY);
      wr(IDX_CTRL, 8'h31, RESP_OKAY);
      wait_ctrl(CTRL_STAT, 1'b1, 1, "stat_on2");
      repeat (10) @(posedge clock);
      wr(IDX_CTRL, 8'h11, RESP_OKAY);
      idle_level <= 1'b1;
      repeat (40) @(posedge clock);
      rd(ba(IDX_CTRL), d, r);
      `CHK("rise_ignored", 1'b0, d[CTRL_EDGE])
      idle_level <= 1'b0;
      wait_ctrl(CTRL_EDGE, 1'b1, 5, "fall_seen");
   endtask

   // A glitch of two sample periods must be dropped, a long level accepted.
   task automatic t_filter;
      logic [7:0] d;
      logic [1:0] r;
      int         rate [4] = '{0, 1, 8, 32};
      for (int c = 0; c < 4; c++) begin
         wr(IDX_IOC, {2'b00, c[1:0], 4'h0}, RESP_OKAY);
         repeat (100) @(posedge clock);
         wr(IDX_CTRL, 8'h11, RESP_OKAY);
         if (c != 0) begin
            idle_level <= 1'b1;
            repeat (2 * rate[c]) @(posedge clock);
            idle_level <= 1'b0;
            repeat (4 * rate[c] + 20) @(posedge clock);
            rd(ba(IDX_CTRL), d, r);
            `CHK("glitch_dropped", 1'b0, d[CTRL_EDGE])
         end
         idle_level <= 1'b1;
         repeat (4 * rate[c] + 10) @(posedge clock);
         idle_level <= 1'b0;
         wait_ctrl(CTRL_EDGE, 1'b1, 10, "level_taken");
      end
   endtask

   task automatic measure(input logic [15:0] h, output logic [7:0] v);
      logic [1:0] r;
      hi_len <= h;
      lo_len <= h;
      repeat (3) begin
         wait_ctrl(CTRL_EDGE, 1'b1, 30, "edge_seen");
         wr(IDX_CTRL, 8'h11, RESP_OKAY);
         rd(ba(IDX_CNT), v, r);
      end
   endtask

   task automatic t_period;
      logic [7:0] v1, v2, v3;
      logic [1:0] r;
      wr(IDX_CTRL, 8'h30, RESP_OKAY);
      wait_ctrl(CTRL_STAT, 1'b0, 3, "stat_off3");
      wr(IDX_IOC, 8'h00, RESP_OKAY);
      wr(IDX_CTRL, 8'h00, RESP_OKAY);
      wr(IDX_CTRL, 8'h31, RESP_OKAY);
      wait_ctrl(CTRL_STAT, 1'b1, 1, "stat_on3");
      run <= 1'b1;
      measure(16'd16, v1);
      measure(16'd24, v2);
      `CHK("period_diff", 8'h04, v1 - v2)
      `CHK("period_range", 1'b1, v1 >= 8'hf7 && v1 <= 8'hfa)
      // The next result is captured and then held while later edges pass.
      wait_ctrl(CTRL_EDGE, 1'b1, 30, "edge_hold");
      wr(IDX_CTRL, 8'h11, RESP_OKAY);
      hi_len <= 16'd16;
      lo_len <= 16'd16;
      repeat (3) begin
         wait_ctrl(CTRL_EDGE, 1'b1, 30, "edge_more");
         wr(IDX_CTRL, 8'h11, RESP_OKAY);
      end
      rd(ba(IDX_CNT), v3, r);
      `CHK("buffer_held", v2, v3)
      run <= 1'b0;
   endtask

   task automatic report_and_stop;
      if (n_mismatch == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog sized well above the longest expected run.
   initial begin
      repeat (60000) @(posedge clock);
      n_mismatch++;
      report_and_stop;
   end

   // Main sequence.
   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, run, idle_level} = 7'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      hi_len = 16'd16;
      lo_len = 16'd16;
      n_mismatch = 0;
      checks = 0;
      irq_n = 0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      t_reset;
      t_start_stop;
      t_flags;
      t_polarity;
      t_filter;
      t_period;
      report_and_stop;
   end
endmodule
